//--- dv/tb.sv
/*
 * Self-checking bench for the line-locked loop register bank.
 * Assumes the design's classic Wishbone slave with a one-cycle ack,
 * and drives the reference pins and loop measurements directly.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0, line_i = 1'b0, field_i = 1'b0, pe_valid = 1'b0;
    logic unlocked = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, junk;
    logic signed [15:0] pe = 16'sh0000;
    logic [19:0] applied = 20'h00000;
    logic [4:0] gain_act = 5'h00, gain_o;
    logic [2:0] damp_o;
    logic [18:0] step_o;
    logic ack_o, off_o, open_o, skew_o, irq_o;
    logic [15:0] samples [3] = '{16'h0010, 16'hFFE0, 16'h0005};
    int errors = 0, checked = 0, skews = 0, n0, n1, s;

    line_locked_loop_regs line_locked_loop_regs_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .line_reference_pulse_i(line_i),
        .field_reference_i(field_i), .phase_err_valid_i(pe_valid),
        .phase_err_i(pe), .applied_step_offset_i(applied),
        .loop_gain_actual_i(gain_act), .loop_unlocked_i(unlocked),
        .loop_gain_setting_o(gain_o), .loop_damping_setting_o(damp_o),
        .oscillator_step_offset_o(step_o), .loop_off_o(off_o),
        .loop_open_o(open_o), .skew_transfer_o(skew_o), .irq_o(irq_o));

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (skew_o === 1'b1) skews++;
    end

    // ****************************************
    // Bus and pin tasks
    // ****************************************
    task end_of_test;
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Wait ends at the edge where ack is sampled high, never earlier
    task wb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
            input logic [3:0] be, output logic [31:0] rd);
        int n;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; sel_i <= be;
        adr_i <= {idx, 2'b00}; dat_i <= {24'h000000, wd};
        n = 0;
        do begin @(posedge clk_i); n++; end
        while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (ack_o !== 1'b1) begin errors++; end_of_test(); end
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] t;
        wb(1'b1, idx, d, 4'h1, t);
    endtask

    task rdchk(input logic [9:0] idx, input logic [7:0] e);
        logic [31:0] t;
        wb(1'b0, idx, 8'h00, 4'h1, t);
        `CHK(t, {24'h000000, e})
    endtask

    // Held long enough to pass the two-flop synchroniser
    task field;
        field_i <= 1'b1; repeat (8) @(posedge clk_i);
        field_i <= 1'b0; repeat (2) @(posedge clk_i);
    endtask

    task skew_lat(input logic [2:0] d, output int n);
        wr(lll_regs_pkg::IDX_SKEW_DELAY, {5'h00, d});
        line_i <= 1'b1;
        n = 0;
        do begin @(posedge clk_i); n++; end
        while (skew_o !== 1'b1 && n < 5000);
        if (skew_o !== 1'b1) begin errors++; end_of_test(); end
        line_i <= 1'b0; repeat (4) @(posedge clk_i);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK({gain_o, damp_o, step_o, open_o, off_o}, 29'h0)
        rdchk(lll_regs_pkg::IDX_PEAK_HI, 8'h00);
        rdchk(10'h3A0, 8'h00);
        wr(lll_regs_pkg::IDX_GAIN_DAMP, 8'hB6);
        rdchk(lll_regs_pkg::IDX_GAIN_DAMP, 8'h00);
        wr(lll_regs_pkg::IDX_STEP_TOP, 8'h25);
        wr(lll_regs_pkg::IDX_STEP_MID, 8'hAB);
        wr(lll_regs_pkg::IDX_STEP_LOW, 8'hCD);
        // Mid byte alone must not reach the loop
        wr(lll_regs_pkg::IDX_STEP_MID, 8'h11);
        `CHK({gain_o, step_o, open_o}, 25'h0)
        for (int i = 0; i < 3; i++) begin
            pe_valid <= 1'b1; pe <= samples[i]; @(posedge clk_i);
        end
        pe_valid <= 1'b0;
        applied <= 20'hA1234; gain_act <= 5'h13; unlocked <= 1'b1;
        field();
        `CHK(gain_o, 5'h16)
        `CHK(damp_o, 3'h5)
        `CHK(step_o, 19'h5ABCD)
        `CHK(open_o, 1'b1)
        rdchk(lll_regs_pkg::IDX_PEAK_HI, 8'h00);
        rdchk(lll_regs_pkg::IDX_PEAK_LO, 8'h10);
        rdchk(lll_regs_pkg::IDX_FLOOR_HI, 8'hFF);
        rdchk(lll_regs_pkg::IDX_FLOOR_LO, 8'hE0);
        rdchk(lll_regs_pkg::IDX_TOTAL_HI, 8'hFF);
        rdchk(lll_regs_pkg::IDX_TOTAL_LO, 8'hF5);
        rdchk(lll_regs_pkg::IDX_MAGN_HI, 8'h00);
        rdchk(lll_regs_pkg::IDX_MAGN_LO, 8'h35);
        rdchk(lll_regs_pkg::IDX_APPLIED_TOP, 8'h0A);
        rdchk(lll_regs_pkg::IDX_APPLIED_MID, 8'h12);
        rdchk(lll_regs_pkg::IDX_APPLIED_LOW, 8'h34);
        rdchk(lll_regs_pkg::IDX_GAIN_ACTUAL, 8'h13);
        rdchk(lll_regs_pkg::IDX_LOCK_STATE, 8'h01);
        // Interrupt: status sticky, masked, then cleared
        rdchk(lll_regs_pkg::IDX_IRQ_STATUS, 8'h05);
        `CHK(irq_o, 1'b0)
        wr(lll_regs_pkg::IDX_IRQ_MASK, 8'h07);
        `CHK(irq_o, 1'b1)
        wr(lll_regs_pkg::IDX_IRQ_STATUS, 8'h07);
        `CHK(irq_o, 1'b0)
        rdchk(lll_regs_pkg::IDX_IRQ_STATUS, 8'h00);
        // A write without the low byte lane leaves the mask alone
        wb(1'b1, lll_regs_pkg::IDX_IRQ_MASK, 8'h00, 4'hE, junk);
        rdchk(lll_regs_pkg::IDX_IRQ_MASK, 8'h07);
        // Snapshot between high and low read keeps the pair intact
        rdchk(lll_regs_pkg::IDX_PEAK_HI, 8'h00);
        pe_valid <= 1'b1; pe <= 16'sh1234; applied <= 20'h0FFFF;
        @(posedge clk_i);
        pe_valid <= 1'b0;
        wr(lll_regs_pkg::IDX_STEP_TOP, 8'h65);
        rdchk(lll_regs_pkg::IDX_PEAK_LO, 8'h10);
        rdchk(lll_regs_pkg::IDX_PEAK_HI, 8'h12);
        rdchk(lll_regs_pkg::IDX_PEAK_LO, 8'h34);
        rdchk(lll_regs_pkg::IDX_APPLIED_TOP, 8'h00);
        rdchk(lll_regs_pkg::IDX_IRQ_STATUS, 8'h02);
        `CHK(off_o, 1'b0)
        // Loop off acts at once; open loop waits for the field edge
        wr(lll_regs_pkg::IDX_STEP_TOP, 8'h15);
        `CHK(off_o, 1'b1)
        `CHK(open_o, 1'b1)
        s = skews;
        line_i <= 1'b1; repeat (1100) @(posedge clk_i);
        line_i <= 1'b0; repeat (4) @(posedge clk_i);
        `CHK(skews, s)
        wr(lll_regs_pkg::IDX_STEP_TOP, 8'h05);
        skew_lat(3'h0, n0);
        skew_lat(3'h7, n1);
        `CHK(n0 >= 514 && n0 <= 517, 1'b1)
        `CHK(n1 - n0, 7 * lll_regs_pkg::SKEW_UNIT)
        end_of_test();
    end
endmodule

//--- include/lll_regs_pkg.sv
/*
 * Constants of the line-locked loop register bank: register indices,
 * field positions, reset values and timing counts.
 * Assumes a Wishbone byte address of four times the register index.
 */
package lll_regs_pkg;
    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [9:0] IDX_PEAK_HI = 10'h325;
    localparam logic [9:0] IDX_PEAK_LO = 10'h326;
    localparam logic [9:0] IDX_FLOOR_HI = 10'h327;
    localparam logic [9:0] IDX_FLOOR_LO = 10'h328;
    localparam logic [9:0] IDX_TOTAL_HI = 10'h329;
    localparam logic [9:0] IDX_TOTAL_LO = 10'h32A;
    localparam logic [9:0] IDX_MAGN_HI = 10'h32B;
    localparam logic [9:0] IDX_MAGN_LO = 10'h32C;
    localparam logic [9:0] IDX_APPLIED_TOP = 10'h32D;
    localparam logic [9:0] IDX_APPLIED_MID = 10'h32E;
    localparam logic [9:0] IDX_APPLIED_LOW = 10'h32F;
    localparam logic [9:0] IDX_GAIN_ACTUAL = 10'h330;
    localparam logic [9:0] IDX_LOCK_STATE = 10'h331;
    localparam logic [9:0] IDX_GAIN_DAMP = 10'h375;
    localparam logic [9:0] IDX_STEP_TOP = 10'h376;
    localparam logic [9:0] IDX_STEP_MID = 10'h377;
    localparam logic [9:0] IDX_STEP_LOW = 10'h378;
    localparam logic [9:0] IDX_SKEW_DELAY = 10'h379;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h390;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h391;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int GAIN_LSB = 0;
    localparam int DAMP_LSB = 5;
    localparam int OFF_BIT = 4;
    localparam int OPEN_BIT = 5;
    localparam int SNAP_BIT = 6;
    localparam int IRQ_FIELD = 0;
    localparam int IRQ_SNAP = 1;
    localparam int IRQ_UNLOCK = 2;
    localparam int IRQ_W = 3;
    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [4:0] GAIN_RST = 5'h00;
    localparam logic [2:0] DAMP_RST = 3'h0;
    localparam logic [18:0] STEP_RST = 19'h00000;
    localparam logic [2:0] SKEW_RST = 3'h0;
    localparam logic [15:0] PEAK_INIT = 16'h8000;
    localparam logic [15:0] FLOOR_INIT = 16'h7FFF;
    localparam int SKEW_UNIT = 512;
endpackage

//--- rtl/line_locked_loop_regs.sv
/*
 * Control and status register bank of a line-locked loop around a
 * numeric oscillator, with per-field phase error statistics.
 * Assumes a classic Wishbone master on clk_i, phase error samples and
 * loop status from logic on clk_i, and line and field references
 * arriving from pins.
 */
// Summary of operation
// - Gain setting is bits 4..0, values 0..31
// - Damping setting is bits 7..5, values 0..7
// - 19-bit signed step offset over three bytes
// - Low byte write transfers all 19 bits
// - Loop-off bit 4 holds oscillator frequency
// - Bit 5 selects open loop when set
// - Skew transfer 512*(1+delay) clocks after line reference
// - Per-field peak and floor, 16 bits each
// - Per-field signed error sum, 16 bits
// - Per-field absolute error sum, 16 bits
// - Statistic word read as coherent high/low pair
// - Applied offset 20-bit signed, top nibble only
// - Applied offset read as coherent three bytes
// - Lock state bit 0, one means unlocked
`timescale 1ns/1ps
module line_locked_loop_regs (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Timing reference pins
    input wire logic line_reference_pulse_i,
    input wire logic field_reference_i,
    // Loop measurements
    input wire logic phase_err_valid_i,
    input wire logic signed [15:0] phase_err_i,
    input wire logic [19:0] applied_step_offset_i,
    input wire logic [4:0] loop_gain_actual_i,
    input wire logic loop_unlocked_i,
    // Loop controls
    output logic [4:0] loop_gain_setting_o,
    output logic [2:0] loop_damping_setting_o,
    output logic [18:0] oscillator_step_offset_o,
    output logic loop_off_o,
    output logic loop_open_o,
    output logic skew_transfer_o,
    // Interrupt
    output logic irq_o
);
    // ****************************************
    // Bus decode
    // ****************************************
    function automatic logic hit(input logic [9:0] a, input logic [9:0] k);
        return a == k;
    endfunction

    wire req = cyc_i & stb_i & ~ack_o;
    wire [9:0] idx = adr_i[11:2];
    wire wr = req & we_i & sel_i[0];
    wire rd = req & ~we_i;
    wire wr_gd = wr & hit(idx, lll_regs_pkg::IDX_GAIN_DAMP);
    wire wr_top = wr & hit(idx, lll_regs_pkg::IDX_STEP_TOP);
    wire wr_mid = wr & hit(idx, lll_regs_pkg::IDX_STEP_MID);
    wire wr_low = wr & hit(idx, lll_regs_pkg::IDX_STEP_LOW);
    wire wr_skew = wr & hit(idx, lll_regs_pkg::IDX_SKEW_DELAY);
    wire wr_stat = wr & hit(idx, lll_regs_pkg::IDX_IRQ_STATUS);
    wire wr_mask = wr & hit(idx, lll_regs_pkg::IDX_IRQ_MASK);
    wire rd_peak_hi = rd & hit(idx, lll_regs_pkg::IDX_PEAK_HI);
    wire rd_floor_hi = rd & hit(idx, lll_regs_pkg::IDX_FLOOR_HI);
    wire rd_total_hi = rd & hit(idx, lll_regs_pkg::IDX_TOTAL_HI);
    wire rd_magn_hi = rd & hit(idx, lll_regs_pkg::IDX_MAGN_HI);
    wire rd_app_top = rd & hit(idx, lll_regs_pkg::IDX_APPLIED_TOP);
    wire snap_pulse = wr_top & dat_i[lll_regs_pkg::SNAP_BIT];

    // ****************************************
    // Reference synchronisers
    // ****************************************
    logic [2:0] line_sync;
    logic [2:0] field_sync;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            line_sync <= 3'h0;
            field_sync <= 3'h0;
        end else begin
            line_sync <= {line_sync[1:0], line_reference_pulse_i};
            field_sync <= {field_sync[1:0], field_reference_i};
        end
    end
    wire line_edge = line_sync[1] & ~line_sync[2];
    wire field_pulse = field_sync[1] & ~field_sync[2];

    // ****************************************
    // Write side
    // ****************************************
    logic [7:0] gd_shadow;
    logic [2:0] top_shadow;
    logic [7:0] mid_shadow;
    logic open_shadow;
    logic [18:0] step_pend;
    logic [2:0] skew_delay;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gd_shadow <= {lll_regs_pkg::DAMP_RST, lll_regs_pkg::GAIN_RST};
            top_shadow <= 3'h0;
            mid_shadow <= 8'h00;
            open_shadow <= 1'b0;
            step_pend <= lll_regs_pkg::STEP_RST;
            skew_delay <= lll_regs_pkg::SKEW_RST;
            loop_off_o <= 1'b0;
        end else begin
            if (wr_gd) begin
                gd_shadow <= dat_i[7:0];
            end
            if (wr_top) begin
                top_shadow <= dat_i[2:0];
                loop_off_o <= dat_i[lll_regs_pkg::OFF_BIT];
                open_shadow <= dat_i[lll_regs_pkg::OPEN_BIT];
            end
            if (wr_mid) begin
                mid_shadow <= dat_i[7:0];
            end
            if (wr_low) begin
                step_pend <= {top_shadow, mid_shadow, dat_i[7:0]};
            end
            if (wr_skew) begin
                skew_delay <= dat_i[2:0];
            end
        end
    end

    // Gain, damping, step offset and open loop reach the loop only at a field boundary
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_gain_setting_o <= lll_regs_pkg::GAIN_RST;
            loop_damping_setting_o <= lll_regs_pkg::DAMP_RST;
            oscillator_step_offset_o <= lll_regs_pkg::STEP_RST;
            loop_open_o <= 1'b0;
        end else if (field_pulse) begin
            loop_gain_setting_o <= gd_shadow[lll_regs_pkg::GAIN_LSB +: 5];
            loop_damping_setting_o <= gd_shadow[lll_regs_pkg::DAMP_LSB +: 3];
            oscillator_step_offset_o <= step_pend;
            loop_open_o <= open_shadow;
        end
    end

    // ****************************************
    // Skew transfer timer
    // ****************************************
    // Longest wait is 8*512 = 4096 clocks, fits 13 bits
    logic [12:0] skew_cnt;
    wire [12:0] skew_load =
        13'(lll_regs_pkg::SKEW_UNIT * (int'(skew_delay) + 1) - 1);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            skew_cnt <= 13'h0000;
            skew_transfer_o <= 1'b0;
        end else begin
            if (line_edge) begin
                skew_cnt <= skew_load;
            end else if (skew_cnt != 13'h0000) begin
                skew_cnt <= skew_cnt - 13'h0001;
            end
            // A held loop takes no new skew
            skew_transfer_o <= (skew_cnt == 13'h0001) & ~line_edge
                & ~loop_off_o;
        end
    end

    // ****************************************
    // Phase error statistics
    // ****************************************
    logic signed [15:0] run_peak;
    logic signed [15:0] run_floor;
    logic [15:0] run_total;
    logic [15:0] run_magn;
    wire signed [15:0] base_peak =
        field_pulse ? lll_regs_pkg::PEAK_INIT : run_peak;
    wire signed [15:0] base_floor =
        field_pulse ? lll_regs_pkg::FLOOR_INIT : run_floor;
    wire [15:0] base_total = field_pulse ? 16'h0000 : run_total;
    wire [15:0] base_magn = field_pulse ? 16'h0000 : run_magn;
    wire [15:0] err_abs = phase_err_i[15] ? 16'(-phase_err_i)
        : phase_err_i;
    wire signed [15:0] next_peak =
        (phase_err_valid_i && phase_err_i > base_peak) ?
        phase_err_i : base_peak;
    wire signed [15:0] next_floor =
        (phase_err_valid_i && phase_err_i < base_floor) ?
        phase_err_i : base_floor;
    wire [15:0] next_total = phase_err_valid_i ?
        16'(base_total + phase_err_i) : base_total;
    wire [15:0] next_magn = phase_err_valid_i ?
        16'(base_magn + err_abs) : base_magn;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_peak <= lll_regs_pkg::PEAK_INIT;
            run_floor <= lll_regs_pkg::FLOOR_INIT;
            run_total <= 16'h0000;
            run_magn <= 16'h0000;
        end else begin
            run_peak <= next_peak;
            run_floor <= next_floor;
            run_total <= next_total;
            run_magn <= next_magn;
        end
    end

    // ****************************************
    // Captured results
    // ****************************************
    logic [15:0] res_peak;
    logic [15:0] res_floor;
    logic [15:0] res_total;
    logic [15:0] res_magn;
    logic [19:0] res_applied;
    logic [4:0] res_gain;
    logic res_lock;
    wire capture = field_pulse | snap_pulse;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_peak <= 16'h0000;
            res_floor <= 16'h0000;
            res_total <= 16'h0000;
            res_magn <= 16'h0000;
            res_applied <= 20'h00000;
            res_gain <= 5'h00;
            res_lock <= 1'b0;
        end else if (capture) begin
            res_peak <= run_peak;
            res_floor <= run_floor;
            res_total <= run_total;
            res_magn <= run_magn;
            res_applied <= applied_step_offset_i;
            res_gain <= loop_gain_actual_i;
            res_lock <= loop_unlocked_i;
        end
    end

    // Low bytes come from a hold filled by the high-byte read
    logic [7:0] hold_peak;
    logic [7:0] hold_floor;
    logic [7:0] hold_total;
    logic [7:0] hold_magn;
    logic [15:0] hold_app;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_peak <= 8'h00;
            hold_floor <= 8'h00;
            hold_total <= 8'h00;
            hold_magn <= 8'h00;
            hold_app <= 16'h0000;
        end else begin
            if (rd_peak_hi) hold_peak <= res_peak[7:0];
            if (rd_floor_hi) hold_floor <= res_floor[7:0];
            if (rd_total_hi) hold_total <= res_total[7:0];
            if (rd_magn_hi) hold_magn <= res_magn[7:0];
            if (rd_app_top) hold_app <= res_applied[15:0];
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic unlocked_q;
    wire [2:0] irq_event = {loop_unlocked_i & ~unlocked_q, snap_pulse,
        field_pulse};
    wire [2:0] irq_clr = wr_stat ? dat_i[2:0] : 3'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            unlocked_q <= 1'b0;
        end else begin
            // A new event beats a clear in the same cycle
            irq_stat <= (irq_stat & ~irq_clr) | irq_event;
            unlocked_q <= loop_unlocked_i;
            if (wr_mask) irq_mask <= dat_i[2:0];
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    // ****************************************
    // Read mux and acknowledge
    // ****************************************
    // Write-only and unmapped words read as zero
    logic [7:0] rd_byte;
    always_comb begin
        case (idx)
            lll_regs_pkg::IDX_PEAK_HI: rd_byte = res_peak[15:8];
            lll_regs_pkg::IDX_PEAK_LO: rd_byte = hold_peak;
            lll_regs_pkg::IDX_FLOOR_HI: rd_byte = res_floor[15:8];
            lll_regs_pkg::IDX_FLOOR_LO: rd_byte = hold_floor;
            lll_regs_pkg::IDX_TOTAL_HI: rd_byte = res_total[15:8];
            lll_regs_pkg::IDX_TOTAL_LO: rd_byte = hold_total;
            lll_regs_pkg::IDX_MAGN_HI: rd_byte = res_magn[15:8];
            lll_regs_pkg::IDX_MAGN_LO: rd_byte = hold_magn;
            lll_regs_pkg::IDX_APPLIED_TOP:
                rd_byte = {4'h0, res_applied[19:16]};
            lll_regs_pkg::IDX_APPLIED_MID: rd_byte = hold_app[15:8];
            lll_regs_pkg::IDX_APPLIED_LOW: rd_byte = hold_app[7:0];
            lll_regs_pkg::IDX_GAIN_ACTUAL: rd_byte = {3'h0, res_gain};
            lll_regs_pkg::IDX_LOCK_STATE: rd_byte = {7'h00, res_lock};
            lll_regs_pkg::IDX_IRQ_STATUS: rd_byte = {5'h00, irq_stat};
            lll_regs_pkg::IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req;
            if (rd) dat_o <= {24'h000000, rd_byte};
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    logic [12:0] since_edge;
    logic [2:0] dly_at_edge;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            since_edge <= 13'h0000;
            dly_at_edge <= 3'h0;
        end else if (line_edge) begin
            since_edge <= 13'h0001;
            dly_at_edge <= skew_delay;
        end else if (since_edge != 13'h1FFF) begin
            since_edge <= since_edge + 13'h0001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // No capture may fall between the two halves of the pair
    sequence s_peak_hi_read;
        (rd_peak_hi && !capture) ##1 (ack_o && !capture);
    endsequence
    sequence s_lo_read_next;
        !capture ##1
        (rd && !capture && hit(idx, lll_regs_pkg::IDX_PEAK_LO));
    endsequence

    chk_gain_apply: assert property (
        field_pulse |=> loop_gain_setting_o == $past(gd_shadow[4:0]))
        else $error("gain not applied at field boundary");
    chk_damp_apply: assert property (
        field_pulse |=> loop_damping_setting_o == $past(gd_shadow[7:5]))
        else $error("damping not applied at field boundary");
    chk_step_xfer: assert property (
        wr_low |=> step_pend == {$past(top_shadow), $past(mid_shadow),
        $past(dat_i[7:0])})
        else $error("step offset not assembled on low write");
    chk_step_hold: assert property (
        (wr_top || wr_mid) |=> $stable(step_pend))
        else $error("step offset moved before low write");
    chk_loop_off: assert property (
        loop_off_o |-> ##1 !skew_transfer_o)
        else $error("skew taken while loop held");
    chk_open_apply: assert property (
        field_pulse |=> loop_open_o == $past(open_shadow))
        else $error("open loop not applied at field boundary");
    chk_skew_time: assert property (
        skew_transfer_o |-> since_edge ==
        13'(lll_regs_pkg::SKEW_UNIT * (int'(dly_at_edge) + 1)))
        else $error("skew transfer at wrong distance");
    chk_peak_capture: assert property (
        field_pulse |=> res_peak == $past(run_peak)
        && res_floor == $past(run_floor))
        else $error("peak or floor not captured");
    chk_total_sum: assert property (
        (phase_err_valid_i && !field_pulse) |=>
        run_total == 16'($past(run_total) + $past(phase_err_i)))
        else $error("signed sum wrong");
    chk_magn_sum: assert property (
        (phase_err_valid_i && !field_pulse) |=>
        run_magn == 16'($past(run_magn) + $past(err_abs)))
        else $error("absolute sum wrong");
    chk_pair_read: assert property (
        s_peak_hi_read ##1 s_lo_read_next |=>
        dat_o[7:0] == $past(res_peak[7:0]))
        else $error("low byte not from held word");
    chk_applied_top: assert property (
        rd_app_top |=> dat_o[7:4] == 4'h0
        && dat_o[3:0] == $past(res_applied[19:16]))
        else $error("applied top byte wrong");
    chk_applied_hold: assert property (
        rd_app_top |=> hold_app == $past(res_applied[15:0]))
        else $error("applied offset not held");
    chk_lock_byte: assert property (
        (rd && hit(idx, lll_regs_pkg::IDX_LOCK_STATE)) |=>
        dat_o == {31'h00000000, $past(res_lock)})
        else $error("lock byte wrong");
    chk_snap_take: assert property (
        snap_pulse |=> res_applied == $past(applied_step_offset_i)
        && res_total == $past(run_total))
        else $error("snapshot not taken");
    chk_field_only: assert property (
        !field_pulse |=> $stable(oscillator_step_offset_o))
        else $error("step offset changed mid-field");
    chk_bus_ack: assert property (
        req |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle");
endmodule
